/* common/sfspi_pkg.sv */
package sfspi_pkg;

    // Status register layout
    localparam int         SFSPI_SR_W        = 8;
    localparam int         SFSPI_BUSY_BIT    = 0;
    localparam int         SFSPI_WEL_BIT     = 1;
    localparam int         SFSPI_LVL_LO_BIT  = 2;
    localparam int         SFSPI_LVL_HI_BIT  = 3;
    localparam int         SFSPI_AAI_BIT     = 6;
    localparam int         SFSPI_LOCK_BIT    = 7;
    localparam logic [7:0] SFSPI_SR_RESET    = 8'h0C;
    localparam logic [7:0] SFSPI_SR_WR_MASK  = 8'h8C;

    // Opcodes recognised by the front end
    localparam logic [7:0] SFSPI_OP_WR_STATUS = 8'h01;
    localparam logic [7:0] SFSPI_OP_RD_STATUS = 8'h05;
    localparam logic [7:0] SFSPI_OP_SECTOR_ER = 8'h20;
    localparam logic [7:0] SFSPI_OP_BLOCK_ER  = 8'h52;

    // Array geometry
    localparam int SFSPI_ADDR_W       = 24;
    localparam int SFSPI_ARRAY_BYTES  = 1048576;
    localparam int SFSPI_SECTOR_BYTES = 4096;
    localparam int SFSPI_BLOCK_BYTES  = 32768;
    localparam int SFSPI_ARRAY_LSB    = $clog2(SFSPI_ARRAY_BYTES);
    localparam int SFSPI_SECTOR_LSB   = $clog2(SFSPI_SECTOR_BYTES);
    localparam int SFSPI_BLOCK_LSB    = $clog2(SFSPI_BLOCK_BYTES);
    localparam int SFSPI_SECTOR_IDX_W = SFSPI_ARRAY_LSB - SFSPI_SECTOR_LSB;
    localparam int SFSPI_BLOCK_IDX_W  = SFSPI_ARRAY_LSB - SFSPI_BLOCK_LSB;

    // Events passed from the link domain to the core
    typedef enum logic [1:0] {
        SFSPI_EV_NONE      = 2'b00,
        SFSPI_EV_WR_STATUS = 2'b01,
        SFSPI_EV_SECTOR    = 2'b10,
        SFSPI_EV_BLOCK     = 2'b11
    } sfspi_evt_t;

endpackage : sfspi_pkg

/* common/sfspi_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface sfspi_link_if;
    logic                                 evt_tgl;
    sfspi_pkg::sfspi_evt_t                evt_kind;
    logic [sfspi_pkg::SFSPI_ADDR_W-1:0]   evt_data;
    logic                                 rd_phase;
    logic [sfspi_pkg::SFSPI_SR_W-1:0]     status;

    modport link (output evt_tgl, output evt_kind, output evt_data, output rd_phase,
                  input status);
    modport core (input evt_tgl, input evt_kind, input evt_data, input rd_phase,
                  output status);
endinterface : sfspi_link_if

`default_nettype wire

/* src/sfspi_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module sfspi_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // Two stages; only the second stage is read outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= INIT;
            q        <= INIT;
        end else if (en) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : sfspi_sync

`default_nettype wire

/* src/sfspi_link.sv */
`timescale 1ns/1ps
`default_nettype none

module sfspi_link (
    // Link clock and framing
    input  wire logic  sck,
    input  wire logic  rst_n,
    input  wire logic  ce_n,
    // Serial data
    input  wire logic  si,
    input  wire logic  hold_n,
    output logic       so_out,
    // Core side
    sfspi_link_if.link lk
);
    import sfspi_pkg::*;

    logic       frame_clr;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [15:0] addr_reg;
    logic [7:0] byte_next;
    logic [SFSPI_SR_W-1:0] status_s;

    // Deselect wipes the frame at once, even with the clock stopped
    assign frame_clr = ce_n | ~rst_n;
    assign byte_next = {shift_reg[6:0], si};

    // Status copy for read-out; resampled through two stages on every rising sck edge, inside frames too
    sfspi_sync #(.W(SFSPI_SR_W), .INIT('0)) u_st_sync (
        .clk(sck), .rst_n(rst_n), .en(1'b1), .d(lk.status), .q(status_s));

    // Framing and shift-in on the rising edge, stalled while held
    always_ff @(posedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            bit_cnt_reg  <= 3'h0;
            byte_idx_reg <= 2'h0;
            shift_reg    <= 8'h00;
            opcode_reg   <= 8'h00;
            addr_reg     <= 16'h0000;
            lk.rd_phase  <= 1'b0;
        end else if (hold_n) begin
            shift_reg   <= byte_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
                if (byte_idx_reg != 2'h3) begin
                    byte_idx_reg <= byte_idx_reg + 2'h1;
                end
                if (byte_idx_reg == 2'h0) begin
                    opcode_reg  <= byte_next;
                    lk.rd_phase <= (byte_next == SFSPI_OP_RD_STATUS);
                end else begin
                    addr_reg <= {addr_reg[7:0], byte_next};
                end
            end
        end
    end

    // Completed commands hand over with a toggle; data held until next one
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            lk.evt_tgl  <= 1'b0;
            lk.evt_kind <= SFSPI_EV_NONE;
            lk.evt_data <= 24'h000000;
        end else if (!ce_n && hold_n && bit_cnt_reg == 3'h7) begin
            if (byte_idx_reg == 2'h1 && opcode_reg == SFSPI_OP_WR_STATUS) begin
                lk.evt_tgl  <= ~lk.evt_tgl;
                lk.evt_kind <= SFSPI_EV_WR_STATUS;
                lk.evt_data <= {16'h0000, byte_next};
            end else if (byte_idx_reg == 2'h3 && (opcode_reg == SFSPI_OP_SECTOR_ER ||
                         opcode_reg == SFSPI_OP_BLOCK_ER)) begin
                lk.evt_tgl  <= ~lk.evt_tgl;
                lk.evt_kind <= (opcode_reg == SFSPI_OP_BLOCK_ER) ? SFSPI_EV_BLOCK
                                                                 : SFSPI_EV_SECTOR;
                lk.evt_data <= {addr_reg, byte_next};
            end
        end
    end

    // Shift-out on the falling edge, MSB first
    always_ff @(negedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            so_out <= 1'b0;
        end else if (hold_n && lk.rd_phase) begin
            so_out <= status_s[3'h7 - bit_cnt_reg];
        end
    end
endmodule : sfspi_link

`default_nettype wire

/* src/sfspi_top.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Sample input rising edge, drive output falling.
// - Chip enable low selects; stays low per command.
// - Works in SPI modes 0 and 3.
// - Hold entered on hold low with clock low.
// - Hold left on hold high with clock low.
// - Hold edge during clock high waits for low.
// - In hold: output floats, input and clock ignored.
// - Deselect during hold resets the interface logic.
// - Hold lasts while hold input stays low.
// - Lock flag sits in status bit 7.
// - Refuse status write when protect low, lock set.
// - Erase decode uses 4K sectors, 32K blocks.
// - All bytes travel most significant bit first.
// - Early deselect aborts command, returns to standby.
// - Locked flag with protect low freezes lock and both level bits.
module sfspi_top (
    // System clock and reset
    input  wire logic                                   ref_clk,
    input  wire logic                                   rst_n,
    input  wire logic                                   clk_en,
    // Serial link pins
    input  wire logic                                   sck,
    input  wire logic                                   ce_n,
    input  wire logic                                   si,
    input  wire logic                                   hold_n,
    input  wire logic                                   wp_n,
    output logic                                        so_out,
    output logic                                        so_oe_n,
    // Status and control
    output logic [sfspi_pkg::SFSPI_SR_W-1:0]            status_out,
    output logic                                        hold_active,
    output logic                                        wr_status_done,
    output logic                                        wr_status_refused,
    // Erase requests towards the array engine
    output logic                                        erase_req,
    output logic                                        erase_is_block,
    output logic [sfspi_pkg::SFSPI_SECTOR_IDX_W-1:0]    erase_sector_idx,
    output logic [sfspi_pkg::SFSPI_BLOCK_IDX_W-1:0]     erase_block_idx
);
    import sfspi_pkg::*;

    // Positions inside the synchroniser bundle
    localparam int SYNC_W   = 6;
    localparam int S_CE     = 0;
    localparam int S_SCK    = 1;
    localparam int S_HOLD   = 2;
    localparam int S_WP     = 3;
    localparam int S_TGL    = 4;
    localparam int S_RD     = 5;
    localparam logic [SYNC_W-1:0] SYNC_INIT = 6'h0D;

    // Sector index of a byte address
    function automatic logic [SFSPI_SECTOR_IDX_W-1:0] sector_of(
        input logic [SFSPI_ADDR_W-1:0] addr);
        return addr[SFSPI_ARRAY_LSB-1:SFSPI_SECTOR_LSB];
    endfunction : sector_of

    // Block index of a byte address
    function automatic logic [SFSPI_BLOCK_IDX_W-1:0] block_of(
        input logic [SFSPI_ADDR_W-1:0] addr);
        return addr[SFSPI_ARRAY_LSB-1:SFSPI_BLOCK_LSB];
    endfunction : block_of

    // Only the software-writable bits follow the written byte
    function automatic logic [SFSPI_SR_W-1:0] sr_merge(
        input logic [SFSPI_SR_W-1:0] old_v,
        input logic [SFSPI_SR_W-1:0] new_v);
        return (old_v & ~SFSPI_SR_WR_MASK) | (new_v & SFSPI_SR_WR_MASK);
    endfunction : sr_merge

    sfspi_link_if lk ();

    logic [SYNC_W-1:0]     sync_d;
    logic [SYNC_W-1:0]     sync_q;
    logic                  ce_s;
    logic                  sck_s;
    logic                  hold_s;
    logic                  wp_s;
    logic                  tgl_s;
    logic                  rd_s;
    logic                  tgl_seen_reg;
    logic                  evt_new;
    logic                  wr_evt;
    logic                  er_evt;
    logic                  wr_allowed;
    logic                  hold_reg;
    logic                  hold_next;
    logic                  oe_n_reg;
    logic [SFSPI_SR_W-1:0] status_reg;

    // Serial-clock side of the front end
    sfspi_link u_link (
        .sck    (sck),
        .rst_n  (rst_n),
        .ce_n   (ce_n),
        .si     (si),
        .hold_n (hold_n),
        .so_out (so_out),
        .lk     (lk.link)
    );

    // Pins and link flags enter the system clock through two stages
    assign sync_d = {lk.rd_phase, lk.evt_tgl, wp_n, hold_n, sck, ce_n};

    sfspi_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .en    (clk_en),
        .d     (sync_d),
        .q     (sync_q)
    );

    assign ce_s   = sync_q[S_CE];
    assign sck_s  = sync_q[S_SCK];
    assign hold_s = sync_q[S_HOLD];
    assign wp_s   = sync_q[S_WP];
    assign tgl_s  = sync_q[S_TGL];
    assign rd_s   = sync_q[S_RD];

    // Event decode; kind and data are settled long before the toggle lands
    assign evt_new    = tgl_s ^ tgl_seen_reg;
    assign wr_evt     = evt_new && (lk.evt_kind == SFSPI_EV_WR_STATUS);
    assign er_evt     = evt_new && (lk.evt_kind == SFSPI_EV_SECTOR ||
                                    lk.evt_kind == SFSPI_EV_BLOCK);
    assign wr_allowed = wp_s || !status_reg[SFSPI_LOCK_BIT];

    // Toggle tracker for link events
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_seen_reg <= 1'b0;
        end else if (clk_en) begin
            tgl_seen_reg <= tgl_s;
        end
    end

    // Hold follows its pin only while clock is low and device selected
    always_comb begin
        hold_next = hold_reg;
        if (ce_s) begin
            hold_next = 1'b0;
        end else if (!sck_s) begin
            hold_next = !hold_s;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 1'b0;
        end else if (clk_en) begin
            hold_reg <= hold_next;
        end
    end

    // Output enable: drive only while reading, selected and not held
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_reg <= 1'b1;
        end else if (clk_en) begin
            oe_n_reg <= ce_s || hold_reg || !rd_s;
        end
    end

    // Status register; with protect low the lock freezes itself and both level bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= SFSPI_SR_RESET;
        end else if (clk_en && wr_evt && wr_allowed) begin
            status_reg <= sr_merge(status_reg, lk.evt_data[SFSPI_SR_W-1:0]);
        end
    end

    // Outcome pulses of a status write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_status_done    <= 1'b0;
            wr_status_refused <= 1'b0;
        end else if (clk_en) begin
            wr_status_done    <= wr_evt && wr_allowed;
            wr_status_refused <= wr_evt && !wr_allowed;
        end
    end

    // Erase address split into sector and block; range check left to the engine
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            erase_req        <= 1'b0;
            erase_is_block   <= 1'b0;
            erase_sector_idx <= '0;
            erase_block_idx  <= '0;
        end else if (clk_en) begin
            erase_req <= er_evt;
            if (er_evt) begin
                erase_is_block   <= (lk.evt_kind == SFSPI_EV_BLOCK);
                erase_sector_idx <= sector_of(lk.evt_data);
                erase_block_idx  <= block_of(lk.evt_data);
            end
        end
    end

    assign lk.status   = status_reg;
    assign status_out  = status_reg;
    assign hold_active = hold_reg;
    assign so_oe_n     = oe_n_reg;

    // Checks on the system-clock side
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence sel_clk_low;
        clk_en && !ce_s && !sck_s;
    endsequence

    sequence sel_clk_high;
        clk_en && !ce_s && sck_s;
    endsequence

    sequence locked_write;
        clk_en && wr_evt && !wp_s && status_reg[SFSPI_LOCK_BIT];
    endsequence

    hold_enter_a: assert property (
        (sel_clk_low and (clk_en && !hold_s)) |=> hold_active)
        else $error("hold not entered with clock low");

    hold_exit_a: assert property (
        (sel_clk_low and (clk_en && hold_s)) |=> !hold_active)
        else $error("hold not left with clock low");

    hold_defer_a: assert property (
        sel_clk_high |=> $stable(hold_active))
        else $error("hold changed while clock high");

    hold_stays_a: assert property (
        (clk_en && hold_reg && !hold_s && !ce_s) |=> hold_active)
        else $error("hold dropped while pin still low");

    hold_float_a: assert property (
        (clk_en && hold_reg) |=> so_oe_n)
        else $error("output driven during hold");

    desel_clear_a: assert property (
        (clk_en && ce_s) |=> !hold_active && so_oe_n)
        else $error("deselect did not clear hold");

    desel_float_a: assert property (
        (clk_en && ce_s)[*2] |=> so_oe_n [*2])
        else $error("output driven while deselected");

    lock_refuse_a: assert property (
        locked_write |=> $stable(status_out) && wr_status_refused && !wr_status_done)
        else $error("locked status write was not refused");

    lock_accept_a: assert property (
        (clk_en && wr_evt && wr_allowed) |=> wr_status_done &&
            status_out[SFSPI_LOCK_BIT] == $past(lk.evt_data[SFSPI_LOCK_BIT]))
        else $error("permitted status write lost lock bit");

    level_freeze_a: assert property (
        locked_write |=> status_out[SFSPI_LVL_HI_BIT:SFSPI_LVL_LO_BIT] ==
            $past(status_reg[SFSPI_LVL_HI_BIT:SFSPI_LVL_LO_BIT]))
        else $error("protection level changed while locked");

    erase_decode_a: assert property (
        (clk_en && er_evt) |=> erase_req &&
            erase_sector_idx == sector_of($past(lk.evt_data)) &&
            erase_block_idx == block_of($past(lk.evt_data)))
        else $error("erase index decode wrong");

endmodule : sfspi_top

`default_nettype wire

/* test/sfspi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sfspi_host_model (
    // Pins driven towards the device
    output logic      sck,
    output logic      ce_n,
    output logic      si,
    output logic      hold_n,
    // Resolved serial output line
    input  wire logic so_line
);
    localparam realtime HALF = 62.5;

    // Deselected and idle from time zero
    initial begin
        sck    = 1'b0;
        ce_n   = 1'b1;
        si     = 1'b0;
        hold_n = 1'b1;
    end

    // Clock parks at the mode's idle level before select
    task automatic start(input logic m3);
        sck = m3;
        #HALF;
        ce_n = 1'b0;
        #HALF;
    endtask : start

    // MSB first; bit set while clock low, reply taken on the rise
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si  = tx[i];
            #HALF;
            sck = 1'b1;
            rx[i] = so_line;
            #HALF;
        end
    endtask : xb

    // Released data line shows the inverse, never a stale value
    task automatic stop(input logic m3);
        sck = m3;
        #HALF;
        ce_n = 1'b1;
        si   = ~si;
        #HALF;
    endtask : stop

    // Clock low so a hold edge counts at once
    task automatic low;
        sck = 1'b0;
        #HALF;
    endtask : low

    task automatic hold(input logic v);
        hold_n = v;
        #HALF;
    endtask : hold

    // Wiggle that a held device must not see
    task automatic noise;
        repeat (4) begin
            sck = ~sck;
            si  = ~si;
            #HALF;
        end
    endtask : noise

    task automatic desel;
        ce_n = 1'b1;
        #HALF;
    endtask : desel
endmodule : sfspi_host_model

`default_nettype wire

/* test/serial_flash_spi_front_end_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_flash_spi_front_end_bench;
    import sfspi_pkg::*;

    // Pins and observed outputs
    logic                          ref_clk, rst_n, clk_en, wp_n;
    logic                          sck, ce_n, si, hold_n;
    logic                          so_out, so_oe_n, hold_active;
    logic                          wr_status_done, wr_status_refused;
    logic                          erase_req, erase_is_block;
    logic [7:0]                    status_out, exp_sr, rx;
    logic [SFSPI_SECTOR_IDX_W-1:0] erase_sector_idx, sec_seen;
    logic [SFSPI_BLOCK_IDX_W-1:0]  erase_block_idx, blk_seen;
    logic                          kind_seen;
    wire                           so_line;
    int                            err_total, checked, n_done, n_ref, n_erase;

    // Floats whenever the device does not drive
    assign so_line = so_oe_n ? 1'bz : so_out;

    sfspi_top u_sfspi_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .sck(sck), .ce_n(ce_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so_out(so_out), .so_oe_n(so_oe_n), .status_out(status_out),
        .hold_active(hold_active), .wr_status_done(wr_status_done),
        .wr_status_refused(wr_status_refused), .erase_req(erase_req),
        .erase_is_block(erase_is_block), .erase_sector_idx(erase_sector_idx),
        .erase_block_idx(erase_block_idx)
    );

    sfspi_host_model u_sfspi_host_model (
        .sck(sck), .ce_n(ce_n), .si(si), .hold_n(hold_n), .so_line(so_line)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Pulse tally; one-cycle pulses are caught at every edge
    always @(posedge ref_clk) begin
        if (wr_status_done === 1'b1) n_done++;
        if (wr_status_refused === 1'b1) n_ref++;
        if (erase_req === 1'b1) begin
            n_erase++;
            sec_seen  = erase_sector_idx;
            blk_seen  = erase_block_idx;
            kind_seen = erase_is_block;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // Opcode, then nb bytes of a high byte first; ends deselected
    task automatic cmd(input logic m3, input logic [7:0] op, input logic [23:0] a,
                       input int nb);
        u_sfspi_host_model.start(m3);
        u_sfspi_host_model.xb(op, rx);
        for (int i = 0; i < nb; i++) begin
            u_sfspi_host_model.xb(a[23-8*i -: 8], rx);
        end
        u_sfspi_host_model.stop(m3);
        tick(8);
    endtask : cmd

    task automatic write_status_cmd(input logic [7:0] v, input logic wp, input logic ok);
        int d0, r0;
        d0   = n_done;
        r0   = n_ref;
        wp_n = wp;
        cmd(1'b0, SFSPI_OP_WR_STATUS, {v, 16'h0000}, 1);
        if (ok) exp_sr = (exp_sr & ~SFSPI_SR_WR_MASK) | (v & SFSPI_SR_WR_MASK);
        chk("wr_status_done", 32'(d0 + ok), n_done);
        chk("wr_status_refused", 32'(r0 + !ok), n_ref);
        chk("status_out", exp_sr, status_out);
    endtask : write_status_cmd

    // Every protect and lock combination
    task automatic t_protect;
        write_status_cmd(8'hFF, 1'b1, 1'b1);
        write_status_cmd(8'h00, 1'b0, 1'b0);
        write_status_cmd(8'h00, 1'b1, 1'b1);
        write_status_cmd(8'h84, 1'b0, 1'b1);
    endtask : t_protect

    // Status read back in both clock modes
    task automatic t_read;
        for (int m = 0; m < 2; m++) begin
            cmd(m[0], SFSPI_OP_RD_STATUS, 24'h000000, 1);
            chk("status on so", exp_sr, rx);
            chk("so_oe_n deselected", 1'b1, so_oe_n);
        end
    endtask : t_read

    task automatic t_erase;
        logic [23:0] a;
        int          e0;
        e0 = n_erase;
        a  = 24'h0AB123;
        cmd(1'b0, SFSPI_OP_SECTOR_ER, a, 2);
        chk("erase_req aborted", e0, n_erase);
        cmd(1'b0, SFSPI_OP_SECTOR_ER, a, 3);
        chk("erase_req sector", e0 + 1, n_erase);
        chk("sector index", a[SFSPI_SECTOR_LSB +: SFSPI_SECTOR_IDX_W], sec_seen);
        chk("erase_is_block", 1'b0, kind_seen);
        a = 24'h0D7FFF;
        cmd(1'b0, SFSPI_OP_BLOCK_ER, a, 3);
        chk("erase_req block", e0 + 2, n_erase);
        chk("block index", a[SFSPI_BLOCK_LSB +: SFSPI_BLOCK_IDX_W], blk_seen);
        chk("erase_is_block", 1'b1, kind_seen);
    endtask : t_erase

    // Pause between opcode and data, then a deselect while held
    task automatic t_hold;
        int d0;
        d0   = n_done;
        wp_n = 1'b1;
        u_sfspi_host_model.start(1'b0);
        u_sfspi_host_model.xb(SFSPI_OP_WR_STATUS, rx);
        u_sfspi_host_model.hold(1'b0);
        chk("hold_active clock high", 1'b0, hold_active);
        u_sfspi_host_model.low();
        chk("hold_active", 1'b1, hold_active);
        chk("so_oe_n in hold", 1'b1, so_oe_n);
        u_sfspi_host_model.noise();
        chk("hold_active kept", 1'b1, hold_active);
        u_sfspi_host_model.hold(1'b1);
        chk("hold_active released", 1'b0, hold_active);
        u_sfspi_host_model.xb(8'h08, rx);
        u_sfspi_host_model.stop(1'b0);
        tick(8);
        exp_sr = 8'h08;
        chk("done after hold", d0 + 1, n_done);
        chk("status after hold", exp_sr, status_out);
        u_sfspi_host_model.start(1'b0);
        u_sfspi_host_model.xb(SFSPI_OP_WR_STATUS, rx);
        u_sfspi_host_model.low();
        u_sfspi_host_model.hold(1'b0);
        u_sfspi_host_model.desel();
        u_sfspi_host_model.hold(1'b1);
        chk("hold_active deselect", 1'b0, hold_active);
        cmd(1'b0, 8'h00, 24'h000000, 0);
        chk("no done after reset", d0 + 1, n_done);
        chk("status kept", exp_sr, status_out);
    endtask : t_hold

    // Hold and clocks while deselected leave no trace
    task automatic t_desel;
        int d0;
        d0 = n_done;
        u_sfspi_host_model.hold(1'b0);
        chk("hold_active deselected", 1'b0, hold_active);
        u_sfspi_host_model.xb(SFSPI_OP_WR_STATUS, rx);
        u_sfspi_host_model.xb(8'h00, rx);
        u_sfspi_host_model.hold(1'b1);
        tick(8);
        chk("done deselected", d0, n_done);
        chk("so_oe_n deselected", 1'b1, so_oe_n);
        write_status_cmd(8'h0C, 1'b1, 1'b1);
    endtask : t_desel

    // Frozen system clock holds the write back; it lands once enabled
    task automatic t_freeze;
        int d0;
        d0     = n_done;
        wp_n   = 1'b1;
        clk_en = 1'b0;
        cmd(1'b0, SFSPI_OP_WR_STATUS, 24'h040000, 1);
        chk("done frozen", d0, n_done);
        chk("status frozen", exp_sr, status_out);
        clk_en = 1'b1;
        tick(4);
        exp_sr = 8'h04;
        chk("done after freeze", d0 + 1, n_done);
        chk("status after freeze", exp_sr, status_out);
    endtask : t_freeze

    task automatic give_verdict;
        $display("Checks made %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // Whole run needs roughly 40 us; allow generous slack
    initial begin
        #200000;
        err_total++;
        give_verdict();
    end

    initial begin
        rst_n  = 1'b0;
        clk_en = 1'b1;
        wp_n   = 1'b1;
        exp_sr = 8'h0C;
        repeat (12) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        tick(4);
        chk("status after reset", exp_sr, status_out);
        chk("so_oe_n after reset", 1'b1, so_oe_n);
        t_protect();
        t_read();
        t_erase();
        t_hold();
        t_desel();
        t_freeze();
        give_verdict();
    end
endmodule : serial_flash_spi_front_end_bench

`default_nettype wire
